// ===== cpu_dmem_map.svh
`ifndef CPU_DMEM_MAP_SVH
`define CPU_DMEM_MAP_SVH
// peripheral addresses
`define PADDR_CARRIER_LOW    8'h03
`define PADDR_CARRIER_HIGH   8'h04
`define PADDR_TIMER8_COUNT   8'h05
`define PADDR_TIMER8_MODULO  8'h06
`define PADDR_TABLE_POINTER  8'h40
// data memory layout
`define BUF_BASE_ADDR        4'hC
`define SYS_FIRST_ADDR       7'h74
`define ROW_POINTER_HIGH_ADDR 7'h7D
`define ROW_POINTER_LOW_ADDR 7'h7E
`define STAGING_ADDR         7'h78
`define RF_DATA_FIRST        7'h40
`define BUF_RESET_VALUE      16'h0320
`define CARRIER_HIGH_TOP_BIT 7
`define CTRL_NIBBLES         16
`define RP_BANK_BIT          3
`endif

// ===== cpu_dmem_pkg.sv
package cpu_dmem_pkg;
    typedef enum logic [2:0] {
        OP_NONE        = 3'h0,
        OP_MEM_WRITE   = 3'h1,
        OP_ALU_GEN     = 3'h2,
        OP_PERIPH_WR   = 3'h3,
        OP_PERIPH_RD   = 3'h4,
        OP_TABLE_FETCH = 3'h5,
        OP_RF_READ     = 3'h6,
        OP_RF_WRITE    = 3'h7
    } cpu_op_t;
    typedef enum logic [1:0] {
        ALU_MOVE = 2'h0,
        ALU_ADD  = 2'h1,
        ALU_SUB  = 2'h2,
        ALU_AND  = 2'h3
    } alu_fn_t;
endpackage : cpu_dmem_pkg

// ===== nibble_port_if.sv
`timescale 1ns/10ps
`default_nettype none
interface nibble_port_if;
    logic       we;
    logic [7:0] waddr;
    logic [3:0] wdata;
    logic [7:0] raddr_a;
    logic [3:0] rdata_a;
    modport ctrl (output we, waddr, wdata, raddr_a, input rdata_a);
    modport mem  (input we, waddr, wdata, raddr_a, output rdata_a);
endinterface : nibble_port_if
`default_nettype wire

// ===== nibble_ram.sv
`timescale 1ns/10ps
`default_nettype none
// two banks of 128 nibbles; registered read port
module nibble_ram #(
    parameter int DEPTH = 256
) (
    input  wire logic  clk_sys,
    nibble_port_if.mem port
);
    logic [3:0] cells [DEPTH];

    // write port, no reset: contents are undefined at power up
    always_ff @(posedge clk_sys) begin
        if (port.we) begin
            cells[port.waddr] <= port.wdata;
        end
    end

    // registered read
    always_ff @(posedge clk_sys) begin
        port.rdata_a <= cells[port.raddr_a];
    end
endmodule : nibble_ram
`default_nettype wire

// ===== cpu_dmem_access.sv
`timescale 1ns/10ps
`default_nettype none
`include "cpu_dmem_map.svh"
//Function
// - one row of sixteen nibbles is scratch row
// - row pointer reaches rows zero to seven
// - single op between memory and scratch row
// - scratch row is plain memory too
// - transfer buffer lives at nibbles 0C-0F
// - timer count read-only, modulo write-only
// - carrier low modulo read and write
// - carrier high top bit reads zero
// - table pointer load, unimplemented bits dropped
// - table fetch fills buffer from rom
// - writes to read-only register ignored
// - unused peripheral address reads undefined, ignores writes; the code reads zero
// - rf 00-3F reach control nibbles only
// - rf 40-7F reach data memory nibbles; the code reaches only 40-73, not the system nibbles 74-7F
// - only sixteen control nibbles implemented
// - rf read copies into staging nibble
// - rf write copies staging nibble out
// - address is row bits over column bits
// - system nibbles shared by both banks
// - buffer resets to 0320
module cpu_dmem_access #(
    parameter int ROM_ADDR_BITS = 14
) (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  reset_n,
    // instruction stream
    input  wire logic                  op_valid,
    input  wire cpu_dmem_pkg::cpu_op_t op_code,
    input  wire cpu_dmem_pkg::alu_fn_t alu_fn,
    input  wire logic                  op_bank,
    input  wire logic [6:0]            op_addr,
    input  wire logic [3:0]            op_col,
    input  wire logic [3:0]            op_data,
    input  wire logic [7:0]            op_paddr,
    output logic                       op_done,
    output logic [3:0]                 op_rdata,
    // rom table port
    output logic [15:0]                rom_addr,
    input  wire logic [15:0]           rom_data,
    // peripheral side
    input  wire logic [7:0]            timer8_count_value,
    output logic [7:0]                 timer8_modulo_value,
    output logic                       timer8_modulo_load,
    output logic [7:0]                 carrier_low_period_modulo,
    output logic [7:0]                 carrier_high_period_modulo,
    output logic [15:0]                rom_table_pointer,
    output logic [63:0]                control_nibbles
);
    localparam logic [15:0] TP_MASK = 16'((32'h1 << ROM_ADDR_BITS) - 1);

    logic       rst_meta;
    logic       rst_sync_n;
    logic [6:0] row_pointer;
    logic [3:0] staging;
    logic [3:0] ctrl_mem [`CTRL_NIBBLES];
    logic [15:0] buffer;
    logic [3:0] staging_gen;
    logic       wr_now;
    logic [7:0] wr_addr;
    logic [3:0] wr_data;
    logic [7:0] rd_addr;
    logic       pending;
    cpu_dmem_pkg::cpu_op_t held_op;
    cpu_dmem_pkg::alu_fn_t held_fn;
    logic [7:0] held_addr;
    logic [7:0] gen_addr;
    logic [3:0] peri_rd_lo;
    logic [3:0] peri_rd_hi;
    logic       buf_periph_ld;
    logic       buf_rom_ld;

    nibble_port_if port ();

    nibble_ram #(.DEPTH(256)) u_ram (
        .clk_sys (clk_sys),
        .port    (port)
    );

    // reset release through two flops
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // bank and address merge; system nibbles ignore the bank
    function automatic logic [7:0] mem_index(input logic bank,
                                             input logic [6:0] a);
        logic shared;
        shared = (a >= `SYS_FIRST_ADDR);
        mem_index = {bank & ~shared, a};
    endfunction

    // row pointer names bank and row, column from operand
    function automatic logic [7:0] scratch_index(input logic [6:0] rp,
                                                 input logic [3:0] col);
        scratch_index = {rp[`RP_BANK_BIT], rp[2:0], col};
    endfunction

    function automatic logic [3:0] alu(input cpu_dmem_pkg::alu_fn_t f,
                                       input logic [3:0] a,
                                       input logic [3:0] b);
        unique case (f)
            cpu_dmem_pkg::ALU_MOVE: alu = b;
            cpu_dmem_pkg::ALU_ADD:  alu = 4'(a + b);
            cpu_dmem_pkg::ALU_SUB:  alu = 4'(a - b);
            cpu_dmem_pkg::ALU_AND:  alu = a & b;
        endcase
    endfunction

    assign gen_addr = scratch_index(row_pointer, op_col);

    // ram port: second cycle of an alu gen op writes back
    always_comb begin
        wr_now  = 1'b0;
        wr_addr = mem_index(op_bank, op_addr);
        wr_data = op_data;
        rd_addr = mem_index(op_bank, op_addr);
        if (pending) begin
            wr_addr = held_addr;
            wr_now  = (held_op == cpu_dmem_pkg::OP_ALU_GEN);
            wr_data = alu(held_fn, port.rdata_a, staging_gen);
            rd_addr = held_addr;
        end else if (op_valid) begin
            unique case (op_code)
                cpu_dmem_pkg::OP_MEM_WRITE: begin
                    wr_now = (op_addr < `SYS_FIRST_ADDR);
                end
                cpu_dmem_pkg::OP_RF_WRITE: begin
                    wr_now  = (op_addr >= `RF_DATA_FIRST) &&
                              (op_addr < `SYS_FIRST_ADDR);
                    wr_addr = mem_index(op_bank, op_addr);
                    wr_data = staging;
                end
                default: ;
            endcase
        end
    end

    // alu operand b captured for the write-back cycle
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            staging_gen <= 4'h0;
        end else if (!pending && op_valid &&
                     op_code == cpu_dmem_pkg::OP_ALU_GEN) begin
            staging_gen <= op_data;
        end
    end

    assign port.we      = wr_now;
    assign port.waddr   = wr_addr;
    assign port.wdata   = wr_data;
    assign port.raddr_a = pending ? held_addr :
                          ((op_valid && op_code == cpu_dmem_pkg::OP_ALU_GEN) ?
                           gen_addr : rd_addr);

    // two-cycle sequencing for ops needing a ram read
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pending   <= 1'b0;
            held_op   <= cpu_dmem_pkg::OP_NONE;
            held_fn   <= cpu_dmem_pkg::ALU_MOVE;
            held_addr <= 8'h00;
        end else if (pending) begin
            pending <= 1'b0;
        end else if (op_valid && (op_code == cpu_dmem_pkg::OP_ALU_GEN ||
                     (op_code == cpu_dmem_pkg::OP_RF_READ &&
                      op_addr >= `RF_DATA_FIRST &&
                      op_addr < `SYS_FIRST_ADDR))) begin
            pending   <= 1'b1;
            held_op   <= op_code;
            held_fn   <= alu_fn;
            held_addr <= mem_index(op_bank, op_addr);
        end
    end

    // completion strobe and read data
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            op_done  <= 1'b0;
            op_rdata <= 4'h0;
        end else begin
            op_done <= pending ||
                       (op_valid && !(op_code == cpu_dmem_pkg::OP_ALU_GEN ||
                        (op_code == cpu_dmem_pkg::OP_RF_READ &&
                         op_addr >= `RF_DATA_FIRST &&
                         op_addr < `SYS_FIRST_ADDR)));
            if (pending) begin
                op_rdata <= port.rdata_a;
            end
        end
    end

    // peripheral read mux; unused addresses read zero as a defined stand-in
    always_comb begin
        peri_rd_lo = 4'h0;
        peri_rd_hi = 4'h0;
        unique case (op_paddr)
            `PADDR_TIMER8_COUNT: {peri_rd_hi, peri_rd_lo} =
                                 timer8_count_value;
            `PADDR_CARRIER_LOW:  {peri_rd_hi, peri_rd_lo} =
                                 carrier_low_period_modulo;
            `PADDR_CARRIER_HIGH: {peri_rd_hi, peri_rd_lo} =
                                 carrier_high_period_modulo;
            default: ;
        endcase
    end

    assign buf_periph_ld = op_valid && !pending &&
                           op_code == cpu_dmem_pkg::OP_PERIPH_RD;
    assign buf_rom_ld    = op_valid && !pending &&
                           op_code == cpu_dmem_pkg::OP_TABLE_FETCH;

    // transfer buffer held in flops at nibbles 0C-0F of bank 0
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            buffer <= `BUF_RESET_VALUE;
        end else if (buf_rom_ld) begin
            buffer <= rom_data;
        end else if (buf_periph_ld) begin
            buffer[7:0] <= {peri_rd_hi, peri_rd_lo};
        end else if (wr_now && wr_addr[7:2] ==
                     {2'h0, 4'(`BUF_BASE_ADDR >> 2)}) begin
            buffer[wr_addr[1:0]*4 +: 4] <= wr_data;
        end
    end

    // peripheral writes; read-only and unused targets untouched
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            timer8_modulo_value        <= 8'h00;
            timer8_modulo_load         <= 1'b0;
            carrier_low_period_modulo  <= 8'h00;
            carrier_high_period_modulo <= 8'h00;
            rom_table_pointer          <= 16'h0000;
        end else begin
            timer8_modulo_load <= 1'b0;
            if (op_valid && !pending &&
                op_code == cpu_dmem_pkg::OP_PERIPH_WR) begin
                unique case (op_paddr)
                    `PADDR_TIMER8_MODULO: begin
                        timer8_modulo_value <= buffer[7:0];
                        timer8_modulo_load  <= 1'b1;
                    end
                    `PADDR_CARRIER_LOW:
                        carrier_low_period_modulo <= buffer[7:0];
                    `PADDR_CARRIER_HIGH:
                        carrier_high_period_modulo <=
                            {1'b0, buffer[6:0]};
                    `PADDR_TABLE_POINTER:
                        rom_table_pointer <= buffer & TP_MASK;
                    default: ;
                endcase
            end
        end
    end

    // rom address trails the pointer by one cycle
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rom_addr <= 16'h0000;
        end else begin
            rom_addr <= rom_table_pointer;
        end
    end

    // system nibbles: row pointer and staging, bank independent
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            row_pointer <= 7'h00;
            staging     <= 4'h0;
        end else if (pending && held_op == cpu_dmem_pkg::OP_RF_READ) begin
            staging <= port.rdata_a;
        end else if (op_valid && op_code == cpu_dmem_pkg::OP_RF_READ &&
                     op_addr < `RF_DATA_FIRST) begin
            staging <= op_addr[5:4] == 2'h0 ?
                       ctrl_mem[op_addr[3:0]] : 4'h0;
        end else if (op_valid && op_code == cpu_dmem_pkg::OP_MEM_WRITE) begin
            if (op_addr == `STAGING_ADDR) begin
                staging <= op_data;
            end
            if (op_addr == `ROW_POINTER_HIGH_ADDR) begin
                row_pointer[6:4] <= op_data[2:0];
            end
            if (op_addr == `ROW_POINTER_LOW_ADDR) begin
                row_pointer[3:0] <= op_data;
            end
        end
    end

    // sixteen implemented control nibbles at rf 00-0F
    genvar gi;
    generate
        for (gi = 0; gi < `CTRL_NIBBLES; gi++) begin : g_ctrl
            always_ff @(posedge clk_sys or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    ctrl_mem[gi] <= 4'h0;
                end else if (op_valid && !pending &&
                             op_code == cpu_dmem_pkg::OP_RF_WRITE &&
                             op_addr == 7'(gi)) begin
                    ctrl_mem[gi] <= staging;
                end
            end
            assign control_nibbles[gi*4 +: 4] = ctrl_mem[gi];
        end
    endgenerate

    chk_carrier_top_zero: assert property (@(posedge clk_sys)
        disable iff (!rst_sync_n)
        carrier_high_period_modulo[`CARRIER_HIGH_TOP_BIT] == 1'b0)
        else $error("carrier high top bit set");
    chk_table_ptr_mask: assert property (@(posedge clk_sys)
        disable iff (!rst_sync_n)
        (rom_table_pointer & ~TP_MASK) == 16'h0000)
        else $error("table pointer high bits set");
    chk_fetch_fills_buffer: assert property (@(posedge clk_sys)
        disable iff (!rst_sync_n)
        buf_rom_ld |=> buffer == $past(rom_data))
        else $error("table fetch missed buffer");
    chk_count_read_only: assert property (@(posedge clk_sys)
        disable iff (!rst_sync_n)
        (op_valid && !pending && op_code == cpu_dmem_pkg::OP_PERIPH_WR &&
         op_paddr == `PADDR_TIMER8_COUNT) |=> $stable(timer8_modulo_value)
         && $stable(carrier_low_period_modulo))
        else $error("read-only write changed state");
    chk_periph_get_timer: assert property (@(posedge clk_sys)
        disable iff (!rst_sync_n)
        (buf_periph_ld && op_paddr == `PADDR_TIMER8_COUNT) |=>
        buffer[7:0] == $past(timer8_count_value))
        else $error("count read wrong");
    chk_modulo_write: assert property (@(posedge clk_sys)
        disable iff (!rst_sync_n)
        (op_valid && !pending && op_code == cpu_dmem_pkg::OP_PERIPH_WR &&
         op_paddr == `PADDR_CARRIER_LOW) |=>
        carrier_low_period_modulo == $past(buffer[7:0]))
        else $error("carrier low not written");
    chk_regfile_write_op_ctrl: assert property (@(posedge clk_sys)
        disable iff (!rst_sync_n)
        (op_valid && !pending && op_code == cpu_dmem_pkg::OP_RF_WRITE &&
         op_addr == 7'h02) |=> control_nibbles[11:8] == $past(staging))
        else $error("regfile_write_op lost");
    chk_gen_done: assert property (@(posedge clk_sys)
        disable iff (!rst_sync_n)
        (op_valid && !pending && op_code == cpu_dmem_pkg::OP_ALU_GEN)
        |=> ##1 op_done)
        else $error("gen op not done in two cycles");

    cov_fetch: cover property (@(posedge clk_sys) buf_rom_ld);
    cov_gen: cover property (@(posedge clk_sys) pending &&
        held_op == cpu_dmem_pkg::OP_ALU_GEN);
    cov_regfile_read_op_data: cover property (@(posedge clk_sys) pending &&
        held_op == cpu_dmem_pkg::OP_RF_READ);
endmodule : cpu_dmem_access
`default_nettype wire

// ===== periph_model.sv
`timescale 1ns/10ps
`default_nettype none
// timer and rom stand-in on the far side of the access block
module periph_model (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // timer side
    input  wire logic        tick,
    input  wire logic [7:0]  timer8_modulo_value,
    input  wire logic        timer8_modulo_load,
    output logic [7:0]       timer8_count_value,
    // rom side
    input  wire logic [15:0] rom_addr,
    output logic [15:0]      rom_data
);
    // count reloads from modulo; tick stays low while the cpu reads it
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n)
            timer8_count_value <= 8'h00;
        else if (timer8_modulo_load)
            timer8_count_value <= timer8_modulo_value;
        else if (tick)
            timer8_count_value <= timer8_count_value + 8'h01;
    end
    // word scrambled from its address so a wrong address shows up
    assign rom_data = {~rom_addr[7:0], rom_addr[15:8] ^ 8'h5A};
endmodule // periph_model
`default_nettype wire

// ===== tb_cpu_dmem_access.sv
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_dmem_access;
    // design inputs
    logic                  clk_sys  = 1'b0;
    logic                  reset_n  = 1'b0;
    logic                  op_valid = 1'b0;
    cpu_dmem_pkg::cpu_op_t op_code  = cpu_dmem_pkg::OP_NONE;
    cpu_dmem_pkg::alu_fn_t alu_fn   = cpu_dmem_pkg::ALU_MOVE;
    logic                  op_bank  = 1'b0;
    logic [6:0]            op_addr  = 7'h00;
    logic [3:0]            op_col   = 4'h0;
    logic [3:0]            op_data  = 4'h0;
    logic [7:0]            op_paddr = 8'h00;
    logic                  tick     = 1'b0;
    // design outputs
    logic                  op_done;
    logic [3:0]            op_rdata;
    logic [15:0]           rom_addr;
    logic [15:0]           rom_data;
    logic [7:0]            timer8_count_value;
    logic [7:0]            timer8_modulo_value;
    logic                  timer8_modulo_load;
    logic [7:0]            carrier_low_period_modulo;
    logic [7:0]            carrier_high_period_modulo;
    logic [15:0]           rom_table_pointer;
    logic [63:0]           control_nibbles;
    int                    fail_count = 0;
    int                    compares   = 0;

    cpu_dmem_access #(.ROM_ADDR_BITS(14)) dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .op_valid(op_valid),
        .op_code(op_code), .alu_fn(alu_fn), .op_bank(op_bank),
        .op_addr(op_addr), .op_col(op_col), .op_data(op_data),
        .op_paddr(op_paddr), .op_done(op_done), .op_rdata(op_rdata),
        .rom_addr(rom_addr), .rom_data(rom_data),
        .timer8_count_value(timer8_count_value),
        .timer8_modulo_value(timer8_modulo_value),
        .timer8_modulo_load(timer8_modulo_load),
        .carrier_low_period_modulo(carrier_low_period_modulo),
        .carrier_high_period_modulo(carrier_high_period_modulo),
        .rom_table_pointer(rom_table_pointer),
        .control_nibbles(control_nibbles)
    );

    periph_model periph (
        .clk_sys(clk_sys), .reset_n(reset_n), .tick(tick),
        .timer8_modulo_value(timer8_modulo_value),
        .timer8_modulo_load(timer8_modulo_load),
        .timer8_count_value(timer8_count_value),
        .rom_addr(rom_addr), .rom_data(rom_data)
    );

    // 200 MHz system clock
    always #2.5 clk_sys = ~clk_sys;

    // verdict and end of run, also reached from a hung handshake
    task automatic results();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] exp,
                         input logic [63:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one op at a falling edge; extra idle cycle keeps two-cycle ops apart
    task automatic op(input cpu_dmem_pkg::cpu_op_t c, input logic b,
                      input logic [6:0] a, input logic [3:0] d,
                      input logic [7:0] p);
        int n;
        op_code = c;
        op_bank = b;
        op_addr = a;
        op_data = d;
        op_paddr = p;
        op_valid = 1'b1;
        @(negedge clk_sys);
        op_valid = 1'b0;
        n = 0;
        while (op_done !== 1'b1 && n < 4) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 4) begin
            fail_count++;
            $display("BAD op_done expected 1 seen %b", op_done);
            results();
        end
        @(negedge clk_sys);
    endtask

    task automatic wr(input logic b, input logic [6:0] a,
                      input logic [3:0] d);
        op(cpu_dmem_pkg::OP_MEM_WRITE, b, a, d, 8'h00);
    endtask

    task automatic peripheral_write_op(input logic [7:0] p);
        op(cpu_dmem_pkg::OP_PERIPH_WR, 1'b0, 7'h00, 4'h0, p);
    endtask

    task automatic peripheral_read_op(input logic [7:0] p);
        op(cpu_dmem_pkg::OP_PERIPH_RD, 1'b0, 7'h00, 4'h0, p);
    endtask

    task automatic rf(input logic rd, input logic b, input logic [6:0] a);
        op(rd ? cpu_dmem_pkg::OP_RF_READ : cpu_dmem_pkg::OP_RF_WRITE,
           b, a, 4'h0, 8'h00);
    endtask

    // buffer nibble zero holds the low bits
    task automatic setbuf(input logic [15:0] v);
        for (int i = 0; i < 4; i++)
            wr(1'b0, 7'h0C + 7'(i), v[4*i +: 4]);
    endtask

    initial begin
        logic [63:0] cn;
        logic [15:0] w;
        logic [15:0] ptr;
        logic [3:0]  ex [4];
        ex = '{4'h3, 4'h9, 4'h3, 4'h2};
        repeat (8) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        peripheral_write_op(8'h40);
        check("table pointer", 64'h0320, rom_table_pointer);
        peripheral_write_op(8'h03);
        check("carrier low", 64'h20, carrier_low_period_modulo);
        setbuf(16'hFFFF);
        peripheral_write_op(8'h40);
        check("table pointer", 64'h3FFF, rom_table_pointer);
        check("rom address", 64'h3FFF, rom_addr);
        $display("test reset and pointer done");
        // table fetch lands in all four buffer nibbles
        w = {8'hCB, 8'h12 ^ 8'h5A};
        ptr = w & 16'h3FFF;
        setbuf(16'h1234);
        peripheral_write_op(8'h40);
        op(cpu_dmem_pkg::OP_TABLE_FETCH, 1'b0, 7'h00, 4'h0, 8'h00);
        peripheral_write_op(8'h03);
        check("carrier low", 64'(w[7:0]), carrier_low_period_modulo);
        peripheral_write_op(8'h40);
        check("table pointer", 64'(ptr), rom_table_pointer);
        $display("test table fetch done");
        // timer modulo reloads the count, which is then read back
        setbuf(16'h003C);
        peripheral_write_op(8'h06);
        check("timer modulo", 64'h3C, timer8_modulo_value);
        tick = 1'b1;
        repeat (2) @(negedge clk_sys);
        tick = 1'b0;
        peripheral_read_op(8'h05);
        peripheral_write_op(8'h03);
        check("carrier low", 64'h3E, carrier_low_period_modulo);
        setbuf(16'h0000);
        peripheral_read_op(8'h03);
        peripheral_write_op(8'h06);
        check("timer modulo", 64'h3E, timer8_modulo_value);
        $display("test timer and carrier low done");
        // writes to the count and to an unused address change nothing
        setbuf(16'h0077);
        peripheral_write_op(8'h05);
        peripheral_write_op(8'h07);
        check("timer modulo", 64'h3E, timer8_modulo_value);
        check("carrier low", 64'h3E, carrier_low_period_modulo);
        check("table pointer", 64'(ptr), rom_table_pointer);
        peripheral_read_op(8'h05);
        peripheral_write_op(8'h04);
        check("carrier high", 64'h3E, carrier_high_period_modulo);
        $display("test ignored writes done");
        setbuf(16'h00DA);
        peripheral_write_op(8'h04);
        check("carrier high", 64'h5A, carrier_high_period_modulo);
        setbuf(16'h0000);
        peripheral_read_op(8'h04);
        peripheral_write_op(8'h03);
        check("carrier low", 64'h5A, carrier_low_period_modulo);
        $display("test carrier high done");
        // staging nibble written in one bank, poked from the other
        for (int i = 0; i < 16; i++) begin
            wr(i[0], 7'h78, 4'(i) ^ 4'h5);
            rf(1'b0, ~i[0], 7'(i));
            cn[4*i +: 4] = 4'(i) ^ 4'h5;
        end
        check("control nibbles", cn, control_nibbles);
        rf(1'b1, 1'b1, 7'h03);
        rf(1'b0, 1'b0, 7'h0F);
        cn[63:60] = 4'h6;
        check("control nibbles", cn, control_nibbles);
        wr(1'b1, 7'h45, 4'h9);
        rf(1'b1, 1'b1, 7'h45);
        check("regfile_read_op data", 64'h9, op_rdata);
        rf(1'b0, 1'b0, 7'h46);
        rf(1'b1, 1'b0, 7'h46);
        check("regfile_write_op data", 64'h9, op_rdata);
        rf(1'b0, 1'b1, 7'h00);
        cn[3:0] = 4'h9;
        check("control nibbles", cn, control_nibbles);
        $display("test register file done");
        // scratch row at bank one row five, operand b from op_data
        wr(1'b0, 7'h7D, 4'h0);
        wr(1'b1, 7'h7E, 4'hD);
        wr(1'b1, 7'h53, 4'h6);
        op_col = 4'h3;
        for (int k = 0; k < 4; k++) begin
            alu_fn = cpu_dmem_pkg::alu_fn_t'(k);
            op(cpu_dmem_pkg::OP_ALU_GEN, 1'b0, 7'h48 + 7'(k), 4'h3,
               8'h00);
            rf(1'b1, 1'b0, 7'h48 + 7'(k));
            check("alu result", 64'(ex[k]), op_rdata);
        end
        $display("test scratch row done");
        results();
    end
endmodule // tb_cpu_dmem_access
`default_nettype wire
